// ===== hdl/mbu_pkg.sv
// package of constants and types for the multiply and branch execution unit
//------------------------------------------------------------
// Summary of operation
// - integer products of two bytes go to R1:R0, touch only Z and C, 2 cycles.
// - fractional products shift left once before R1:R0, Z and C, 2 cycles.
// - cipher step encrypts R15:R0 with K when H clear, decrypts when set, 1/2.
// - pointer goto loads PC low sixteen bits from Z, clears bits 21:16, 2 cycles.
// - extended pointer goto takes PC low bits from Z, upper from segment, 2 cycles.
// - pointer call takes Z, clears upper PC bits, 2 or 3 cycles by variant.
// - extended pointer call takes segment and Z into PC, 3 cycles.
// - compare skip equal skips next instruction on equal registers, 1/2/3 cycles.
// - register bit skips on selected bit clear or set, 1/2/3 cycles.
// - I/O bit skips on addressed bit clear or set, 2/3/4 cycles.
// - generic flag branches go to PC+k+1 on selected flag set or clear, 1/2.
// - unsigned compare branches test carry only, clear or set.
// - signed compare branches test N xor V, zero or one.
// - half carry branch goes to PC+k+1 when H is one, 1/2 cycles.
// - zero, carry and sign branches on set or clear, flags unchanged.
`default_nettype none
package mbu_pkg;
	localparam int PC_W   = 22;
	localparam int SEG_W  = 6;
	localparam int K_W    = 12;
	localparam int CYC_W  = 3;
	// device variant with a 22-bit program counter pays an extra call cycle
	localparam bit PC_WIDE = 1'b1;

	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_I = 3'h7;

	localparam logic [CYC_W-1:0] CYC_PROD     = 3'h2;
	localparam logic [CYC_W-1:0] CYC_CIPH_RDY = 3'h1;
	localparam logic [CYC_W-1:0] CYC_CIPH_WT  = 3'h2;
	localparam logic [CYC_W-1:0] CYC_GOTO     = 3'h2;
	localparam logic [CYC_W-1:0] CYC_CALL     = PC_WIDE ? 3'h3 : 3'h2;
	localparam logic [CYC_W-1:0] CYC_ECALL    = 3'h3;
	localparam logic [CYC_W-1:0] CYC_RET      = PC_WIDE ? 3'h5 : 3'h4;
	localparam logic [CYC_W-1:0] CYC_NOTAKE   = 3'h1;
	localparam logic [CYC_W-1:0] CYC_TAKE     = 3'h2;
	localparam logic [CYC_W-1:0] CYC_IO_EXTRA = 3'h1;
	localparam logic [CYC_W-1:0] CYC_ONE      = 3'h1;
	localparam logic [PC_W-1:0]  PC_STEP      = 22'h000001;
	localparam logic [PC_W-1:0]  SKIP_ONE     = 22'h000002;
	localparam logic [PC_W-1:0]  SKIP_TWO     = 22'h000003;

	typedef enum logic [4:0] {
		op_prod_uu, op_prod_ss, op_prod_su,
		op_frac_uu, op_frac_ss, op_frac_su,
		op_cipher,
		op_ptr_goto, op_eptr_goto, op_ptr_call, op_eptr_call,
		op_cmp_skip, op_skip_rbc, op_skip_rbs, op_skip_ioc, op_skip_ios,
		op_br_set, op_br_clr, op_br_sh, op_br_lo, op_br_ge, op_br_lt,
		op_br_hs, op_br_eq, op_br_ne, op_br_cs, op_br_cc, op_br_mi, op_br_pl,
		op_sub_return, op_int_return
	} mbu_op_t;

	typedef enum logic {st_idle, st_run} mbu_state_t;
endpackage
`default_nettype wire

// ===== hdl/mbu_mul_if.sv
// interface between the execution core and its multiplier
`default_nettype none
interface mbu_prod_if;
	logic [7:0]  a;
	logic [7:0]  b;
	logic        a_signed;
	logic        b_signed;
	logic        frac;
	logic [15:0] product;
	logic        zero;
	logic        carry;
	modport unit (input a, b, a_signed, b_signed, frac, output product, zero, carry);
	modport core (output a, b, a_signed, b_signed, frac, input product, zero, carry);
endinterface
`default_nettype wire

// ===== hdl/mbu_mult_unit.sv
// byte multiplier with signed, unsigned, mixed and fractional forms
`default_nettype none
module mbu_mult_unit
	import mbu_pkg::*;
(
	mbu_prod_if.unit m
);
	logic signed [8:0]  sa;
	logic signed [8:0]  sb;
	logic signed [17:0] full;
	logic [15:0]        raw;

	always_comb begin
		sa   = {m.a_signed & m.a[7], m.a};
		sb   = {m.b_signed & m.b[7], m.b};
		full = sa * sb;
		raw  = full[15:0];
		// carry is bit 15 of the product before the fractional shift
		m.carry   = raw[15];
		m.product = m.frac ? {raw[14:0], 1'b0} : raw;
		m.zero    = (m.product == 16'h0000);
	end
endmodule
`default_nettype wire

// ===== hdl/mbu_exec_unit.sv
// multiply, cipher step and control-flow execution unit of the core
`default_nettype none
module mbu_exec_unit
	import mbu_pkg::*;
(
	input  wire logic            sys_clk_in,
	input  wire logic            rst_in,
	input  wire logic            op_valid_in,
	input  wire mbu_op_t         op_in,
	input  wire logic [7:0]      rd_in,
	input  wire logic [7:0]      rr_in,
	input  wire logic [2:0]      bit_sel_in,
	input  wire logic [2:0]      flag_sel_in,
	input  wire logic [K_W-1:0]  k_in,
	input  wire logic [PC_W-1:0] pc_in,
	input  wire logic [15:0]     z_in,
	input  wire logic [SEG_W-1:0] seg_in,
	input  wire logic [7:0]      stat_in,
	input  wire logic [7:0]      io_reg_in,
	input  wire logic            next_two_word_in,
	input  wire logic [PC_W-1:0] stack_data_in,
	input  wire logic            cipher_ready_in,
	output logic                 busy_out,
	output logic                 done_out,
	output logic [PC_W-1:0]      pc_out,
	output logic [15:0]          prod_out,
	output logic                 prod_we_out,
	output logic [7:0]           stat_out,
	output logic                 stat_we_out,
	output logic                 push_out,
	output logic [PC_W-1:0]      push_addr_out,
	output logic                 pop_out,
	output logic                 skip_out,
	output logic                 cipher_start_out,
	output logic                 cipher_decrypt_out
);
	//------------------------------------------------------------
	// multiplier
	//------------------------------------------------------------
	mbu_prod_if mi ();

	mbu_mult_unit u_mult (
		.m (mi.unit)
	);

	assign mi.a        = rd_in;
	assign mi.b        = rr_in;
	assign mi.a_signed = (op_in == op_prod_ss) || (op_in == op_prod_su) ||
	                     (op_in == op_frac_ss) || (op_in == op_frac_su);
	assign mi.b_signed = (op_in == op_prod_ss) || (op_in == op_frac_ss);
	assign mi.frac     = (op_in == op_frac_uu) || (op_in == op_frac_ss) ||
	                     (op_in == op_frac_su);

	//------------------------------------------------------------
	// decode of the presented instruction
	//------------------------------------------------------------
	logic [CYC_W-1:0] cyc_next;
	logic [PC_W-1:0]  pc_next;
	logic [PC_W-1:0]  seq_pc;
	logic [PC_W-1:0]  br_pc;
	logic [PC_W-1:0]  skip_pc;
	logic [CYC_W-1:0] skip_cyc;
	logic [7:0]       stat_next;
	logic             prod_we_next;
	logic             stat_we_next;
	logic             push_next;
	logic             pop_next;
	logic             skip_next;
	logic             cipher_next;
	logic             taken;
	logic             skip_cond;
	logic             is_branch;
	logic             is_skip;
	logic             is_io_skip;
	logic             f_c;
	logic             f_z;
	logic             f_n;
	logic             f_v;
	logic             f_h;

	always_comb begin
		f_c = stat_in[FLAG_C];
		f_z = stat_in[FLAG_Z];
		f_n = stat_in[FLAG_N];
		f_v = stat_in[FLAG_V];
		f_h = stat_in[FLAG_H];
		seq_pc  = pc_in + PC_STEP;
		br_pc   = pc_in + PC_W'($signed(k_in)) + PC_STEP;
		// the skipped instruction's length sets both distance and cost
		skip_pc  = pc_in + (next_two_word_in ? SKIP_TWO : SKIP_ONE);
		skip_cyc = next_two_word_in ? (CYC_TAKE + CYC_ONE) : CYC_TAKE;
		taken      = 1'b0;
		skip_cond  = 1'b0;
		is_branch  = 1'b0;
		is_skip    = 1'b0;
		is_io_skip = 1'b0;
		case (op_in)
			op_br_set: begin
				is_branch = 1'b1;
				taken     = stat_in[flag_sel_in];
			end
			op_br_clr: begin
				is_branch = 1'b1;
				taken     = !stat_in[flag_sel_in];
			end
			op_br_sh: begin
				is_branch = 1'b1;
				taken     = !f_c;
			end
			op_br_lo: begin
				is_branch = 1'b1;
				taken     = f_c;
			end
			op_br_ge: begin
				is_branch = 1'b1;
				taken     = !(f_n ^ f_v);
			end
			op_br_lt: begin
				is_branch = 1'b1;
				taken     = f_n ^ f_v;
			end
			op_br_hs: begin
				is_branch = 1'b1;
				taken     = f_h;
			end
			op_br_eq: begin
				is_branch = 1'b1;
				taken     = f_z;
			end
			op_br_ne: begin
				is_branch = 1'b1;
				taken     = !f_z;
			end
			op_br_cs: begin
				is_branch = 1'b1;
				taken     = f_c;
			end
			op_br_cc: begin
				is_branch = 1'b1;
				taken     = !f_c;
			end
			op_br_mi: begin
				is_branch = 1'b1;
				taken     = f_n;
			end
			op_br_pl: begin
				is_branch = 1'b1;
				taken     = !f_n;
			end
			op_cmp_skip: begin
				is_skip   = 1'b1;
				skip_cond = (rd_in == rr_in);
			end
			op_skip_rbc: begin
				is_skip   = 1'b1;
				skip_cond = !rr_in[bit_sel_in];
			end
			op_skip_rbs: begin
				is_skip   = 1'b1;
				skip_cond = rr_in[bit_sel_in];
			end
			op_skip_ioc: begin
				is_io_skip = 1'b1;
				skip_cond  = !io_reg_in[bit_sel_in];
			end
			op_skip_ios: begin
				is_io_skip = 1'b1;
				skip_cond  = io_reg_in[bit_sel_in];
			end
			default: begin
				taken = 1'b0;
			end
		endcase
	end

	always_comb begin
		cyc_next     = CYC_ONE;
		pc_next      = seq_pc;
		stat_next    = stat_in;
		prod_we_next = 1'b0;
		stat_we_next = 1'b0;
		push_next    = 1'b0;
		pop_next     = 1'b0;
		skip_next    = 1'b0;
		cipher_next  = 1'b0;
		case (op_in)
			op_prod_uu, op_prod_ss, op_prod_su,
			op_frac_uu, op_frac_ss, op_frac_su: begin
				cyc_next             = CYC_PROD;
				prod_we_next         = 1'b1;
				stat_we_next         = 1'b1;
				stat_next[FLAG_Z]    = mi.zero;
				stat_next[FLAG_C]    = mi.carry;
			end
			op_cipher: begin
				// an engine still busy with a previous step costs one more cycle
				cyc_next    = cipher_ready_in ? CYC_CIPH_RDY : CYC_CIPH_WT;
				cipher_next = 1'b1;
			end
			op_ptr_goto: begin
				cyc_next = CYC_GOTO;
				pc_next  = {{SEG_W{1'b0}}, z_in};
			end
			op_eptr_goto: begin
				cyc_next = CYC_GOTO;
				pc_next  = {seg_in, z_in};
			end
			op_ptr_call: begin
				cyc_next  = CYC_CALL;
				pc_next   = {{SEG_W{1'b0}}, z_in};
				push_next = 1'b1;
			end
			op_eptr_call: begin
				cyc_next  = CYC_ECALL;
				pc_next   = {seg_in, z_in};
				push_next = 1'b1;
			end
			op_sub_return: begin
				cyc_next = CYC_RET;
				pc_next  = stack_data_in;
				pop_next = 1'b1;
			end
			op_int_return: begin
				cyc_next          = CYC_RET;
				pc_next           = stack_data_in;
				pop_next          = 1'b1;
				stat_we_next      = 1'b1;
				stat_next[FLAG_I] = 1'b1;
			end
			default: begin
				if (is_branch) begin
					cyc_next = taken ? CYC_TAKE : CYC_NOTAKE;
					pc_next  = taken ? br_pc : seq_pc;
				end else if (is_skip || is_io_skip) begin
					skip_next = skip_cond;
					pc_next   = skip_cond ? skip_pc : seq_pc;
					cyc_next  = skip_cond ? skip_cyc : CYC_NOTAKE;
					if (is_io_skip) begin
						cyc_next = cyc_next + CYC_IO_EXTRA;
					end
				end
			end
		endcase
	end

	//------------------------------------------------------------
	// sequencing
	//------------------------------------------------------------
	mbu_state_t       state_reg;
	logic [CYC_W-1:0] cnt_reg;
	logic             accept;
	logic             finish;

	assign accept = op_valid_in && (state_reg == st_idle);
	// a one-cycle instruction finishes at the edge that takes it
	assign finish = (accept && (cyc_next == CYC_ONE)) ||
	                ((state_reg == st_run) && (cnt_reg == CYC_ONE));

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= st_idle;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				st_idle: begin
					if (accept && (cyc_next != CYC_ONE)) begin
						state_reg <= st_run;
						cnt_reg   <= cyc_next - CYC_ONE;
					end
				end
				st_run: begin
					cnt_reg <= cnt_reg - CYC_ONE;
					if (cnt_reg == CYC_ONE) begin
						state_reg <= st_idle;
					end
				end
				default: begin
					state_reg <= st_idle;
					cnt_reg   <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_out <= 1'b0;
		end else begin
			busy_out <= (accept && (cyc_next != CYC_ONE)) ||
			            ((state_reg == st_run) && (cnt_reg != CYC_ONE));
		end
	end

	//------------------------------------------------------------
	// results held from acceptance, released on finish
	//------------------------------------------------------------
	logic [PC_W-1:0] pc_hold_reg;
	logic [15:0]     prod_hold_reg;
	logic [7:0]      stat_hold_reg;
	logic [PC_W-1:0] ret_hold_reg;
	logic [4:0]      act_hold_reg;
	logic [PC_W-1:0] pc_fin;
	logic [15:0]     prod_fin;
	logic [7:0]      stat_fin;
	logic [PC_W-1:0] ret_fin;
	logic [4:0]      act_fin;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_hold_reg   <= '0;
			prod_hold_reg <= '0;
			stat_hold_reg <= '0;
			ret_hold_reg  <= '0;
			act_hold_reg  <= '0;
		end else if (accept) begin
			pc_hold_reg   <= pc_next;
			prod_hold_reg <= mi.product;
			stat_hold_reg <= stat_next;
			ret_hold_reg  <= seq_pc;
			act_hold_reg  <= {prod_we_next, stat_we_next, push_next,
			                  pop_next, skip_next};
		end
	end

	always_comb begin
		if (accept) begin
			pc_fin   = pc_next;
			prod_fin = mi.product;
			stat_fin = stat_next;
			ret_fin  = seq_pc;
			act_fin  = {prod_we_next, stat_we_next, push_next, pop_next, skip_next};
		end else begin
			pc_fin   = pc_hold_reg;
			prod_fin = prod_hold_reg;
			stat_fin = stat_hold_reg;
			ret_fin  = ret_hold_reg;
			act_fin  = act_hold_reg;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_out      <= 1'b0;
			prod_we_out   <= 1'b0;
			stat_we_out   <= 1'b0;
			push_out      <= 1'b0;
			pop_out       <= 1'b0;
			skip_out      <= 1'b0;
			pc_out        <= '0;
			prod_out      <= '0;
			stat_out      <= '0;
			push_addr_out <= '0;
		end else begin
			done_out    <= finish;
			prod_we_out <= finish && act_fin[4];
			stat_we_out <= finish && act_fin[3];
			push_out    <= finish && act_fin[2];
			pop_out     <= finish && act_fin[1];
			skip_out    <= finish && act_fin[0];
			if (finish) begin
				pc_out        <= pc_fin;
				prod_out      <= prod_fin;
				stat_out      <= stat_fin;
				push_addr_out <= ret_fin;
			end
		end
	end

	//------------------------------------------------------------
	// cipher engine request
	//------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cipher_start_out   <= 1'b0;
			cipher_decrypt_out <= 1'b0;
		end else begin
			cipher_start_out <= accept && cipher_next;
			if (accept && cipher_next) begin
				cipher_decrypt_out <= stat_in[FLAG_H];
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/mbu_exec_unit_assertions.sv
// port-level checks for the multiply and branch execution unit
`default_nettype none
module mbu_exec_unit_assertions
	import mbu_pkg::*;
(
	input wire logic             sys_clk_in,
	input wire logic             rst_in,
	input wire logic             op_valid_in,
	input wire mbu_op_t          op_in,
	input wire logic [7:0]       rd_in,
	input wire logic [7:0]       rr_in,
	input wire logic [2:0]       bit_sel_in,
	input wire logic [2:0]       flag_sel_in,
	input wire logic [K_W-1:0]   k_in,
	input wire logic [PC_W-1:0]  pc_in,
	input wire logic [15:0]      z_in,
	input wire logic [SEG_W-1:0] seg_in,
	input wire logic [7:0]       stat_in,
	input wire logic [7:0]       io_reg_in,
	input wire logic             next_two_word_in,
	input wire logic [PC_W-1:0]  stack_data_in,
	input wire logic             cipher_ready_in,
	input wire logic             busy_out,
	input wire logic             done_out,
	input wire logic [PC_W-1:0]  pc_out,
	input wire logic [15:0]      prod_out,
	input wire logic             prod_we_out,
	input wire logic [7:0]       stat_out,
	input wire logic             stat_we_out,
	input wire logic             push_out,
	input wire logic [PC_W-1:0]  push_addr_out,
	input wire logic             pop_out,
	input wire logic             skip_out,
	input wire logic             cipher_start_out,
	input wire logic             cipher_decrypt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	//----------------------------------------
	// helpers
	//----------------------------------------
	logic acc;
	assign acc = op_valid_in && !busy_out;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	//----------------------------------------
	// assertions
	//----------------------------------------
	a_prod_two_cycles: assert property (acc && op_in <= op_frac_su |=> busy_out && !done_out
		##1 done_out && prod_we_out && stat_we_out) else $error("multiply length wrong");
	a_prod_zero_flag: assert property (prod_we_out |->
		stat_out[FLAG_Z] == (prod_out == 16'h0000)) else $error("product zero flag wrong");
	a_frac_shifted: assert property (acc && op_in inside {op_frac_uu, op_frac_ss, op_frac_su}
		|-> ##2 done_out && prod_out[0] == 1'b0) else $error("fraction not shifted");
	a_goto_from_z: assert property (acc && op_in == op_ptr_goto |-> ##2 done_out
		&& pc_out == {6'h00, $past(z_in, 2)}) else $error("pointer goto target wrong");
	a_egoto_segment: assert property (acc && op_in == op_eptr_goto |-> ##2 done_out
		&& pc_out == {$past(seg_in, 2), $past(z_in, 2)}) else $error("segment goto wrong");
	a_call_push: assert property (acc && op_in == op_ptr_call |=> !done_out [*2] ##1
		(done_out && push_out && push_addr_out == $past(pc_in, 3) + PC_STEP
		&& pc_out[21:16] == 6'h00)) else $error("pointer call wrong");
	a_ecall_three: assert property (acc && op_in == op_eptr_call |=> !done_out [*2] ##1
		(done_out && push_out && pc_out[21:16] == $past(seg_in, 3))) else $error("segment call wrong");
	a_hs_untaken: assert property (acc && op_in == op_br_hs && !stat_in[FLAG_H] |=>
		done_out && !busy_out && pc_out == $past(pc_in) + PC_STEP) else $error("half carry branch");
	a_brset_taken: assert property (acc && op_in == op_br_set && stat_in[flag_sel_in] |=>
		busy_out ##1 done_out && !stat_we_out) else $error("flag branch timing wrong");
	a_lower_carry: assert property (acc && op_in == op_br_lo && !stat_in[FLAG_C] |=>
		done_out && pc_out == $past(pc_in) + PC_STEP) else $error("lower branch taken wrongly");
	a_cipher_direction: assert property (acc && op_in == op_cipher |=> cipher_start_out
		&& cipher_decrypt_out == $past(stat_in[FLAG_H])) else $error("cipher direction wrong");
	a_skip_two_word: assert property (acc && op_in == op_skip_rbs && rr_in[bit_sel_in]
		&& next_two_word_in |=> !done_out [*2] ##1 (done_out && skip_out
		&& pc_out == $past(pc_in, 3) + SKIP_TWO)) else $error("two-word skip wrong");
	a_reti_enable: assert property (pop_out && stat_we_out |->
		done_out && stat_out[FLAG_I]) else $error("interrupt return flag wrong");
	//----------------------------------------
	// coverage
	//----------------------------------------
	c_prod: cover property (prod_we_out);
	c_call: cover property (push_out);
	c_slow_cipher: cover property (acc && op_in == op_cipher && !cipher_ready_in);
endmodule
bind mbu_exec_unit mbu_exec_unit_assertions u_chk (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the multiply and branch execution unit
`default_nettype none
module testbench
	import mbu_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	//----------------------------------------
	// signals
	//----------------------------------------
	logic             sys_clk_in, rst_in, op_valid_in, next_two_word_in, cipher_ready_in;
	mbu_op_t          op_in, op;
	logic [7:0]       rd_in, rr_in, stat_in, io_reg_in, stat_out, c_stat;
	logic [2:0]       bit_sel_in, flag_sel_in;
	logic [K_W-1:0]   k_in;
	logic [PC_W-1:0]  pc_in, stack_data_in, pc_out, push_addr_out, c_pc, c_paddr, adv;
	logic [15:0]      z_in, prod_out, c_prod, p, r;
	logic [SEG_W-1:0] seg_in;
	logic             busy_out, done_out, prod_we_out, stat_we_out, push_out, pop_out;
	logic             skip_out, cipher_start_out, cipher_decrypt_out, tk, sk;
	logic             c_pwe, c_swe, c_push, c_pop, c_skip, c_start, c_dec;
	int               fails, num_checks, cyc;
	logic [7:0]       ma[5] = '{8'h80, 8'hFF, 8'h00, 8'h40, 8'h7F};
	logic [7:0]       mb[5] = '{8'hFF, 8'hFF, 8'h37, 8'h02, 8'h81};
	logic [7:0]       sv[4] = '{8'h00, 8'hFF, 8'h05, 8'h2A};

	mbu_exec_unit dut (.*);

	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	//----------------------------------------
	// tasks
	//----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (fails == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one instruction; an idle cycle after done keeps the valid strobe edges apart
	task automatic run(input mbu_op_t o);
		op_in = o;
		op_valid_in = 1'b1;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		op_valid_in = 1'b0;
		cyc = 1;
		c_start = cipher_start_out;
		while (done_out !== 1'b1 && cyc < 8) begin
			@(negedge sys_clk_in);
			cyc++;
			c_start = c_start | cipher_start_out;
		end
		{c_pc, c_prod, c_stat, c_paddr} = {pc_out, prod_out, stat_out, push_addr_out};
		{c_pwe, c_swe, c_push, c_pop, c_skip} = {prod_we_out, stat_we_out, push_out, pop_out, skip_out};
		c_dec = cipher_decrypt_out;
		@(negedge sys_clk_in);
	endtask

	// raw product: index 0/3 unsigned, 1/4 signed, 2/5 signed by unsigned
	function automatic logic [15:0] mprod(input int k, input logic [7:0] a, input logic [7:0] b);
		logic [31:0] x, y, m;
		x = (k % 3 != 0) ? {{24{a[7]}}, a} : {24'h000000, a};
		y = (k % 3 == 1) ? {{24{b[7]}}, b} : {24'h000000, b};
		m = x * y;
		return m[15:0];
	endfunction

	function automatic logic take(input mbu_op_t o, input logic [7:0] s, input logic [2:0] f);
		case (o)
			op_br_set: return s[f];
			op_br_clr: return !s[f];
			op_br_sh, op_br_cc: return !s[FLAG_C];
			op_br_lo, op_br_cs: return s[FLAG_C];
			op_br_ge: return !(s[FLAG_N] ^ s[FLAG_V]);
			op_br_lt: return s[FLAG_N] ^ s[FLAG_V];
			op_br_hs: return s[FLAG_H];
			op_br_eq: return s[FLAG_Z];
			op_br_ne: return !s[FLAG_Z];
			op_br_mi: return s[FLAG_N];
			default: return !s[FLAG_N];
		endcase
	endfunction
	//----------------------------------------
	// sequence
	//----------------------------------------
	initial begin
		{op_valid_in, next_two_word_in, cipher_ready_in, rd_in, rr_in, stat_in} = '0;
		{io_reg_in, bit_sel_in, flag_sel_in, k_in, pc_in, stack_data_in, z_in, seg_in} = '0;
		op_in = op_prod_uu;
		fails = 0;
		num_checks = 0;
		rst_in = 1'b1;
		repeat (10) @(negedge sys_clk_in);
		rst_in = 1'b0;
		@(negedge sys_clk_in);
		check("outputs after reset", {done_out, push_out, pop_out, pc_out}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 5; j++) begin
				{rd_in, rr_in, stat_in, pc_in} = {ma[j], mb[j], 8'hC3, 22'h000100};
				op = mbu_op_t'(int'(op_prod_uu) + i);
				p = mprod(i, ma[j], mb[j]);
				r = (i >= 3) ? {p[14:0], 1'b0} : p;
				run(op);
				check("prod cycles", cyc, 2);
				check("product", c_prod, r);
				check("prod flags", c_stat, {stat_in[7:2], r == 16'h0000, p[15]});
				check("prod strobes", {c_pwe, c_swe, c_pc}, {2'h3, pc_in + PC_STEP});
			end
		end
		// ready engine gives a single cycle step; busy engine adds one
		{stat_in, cipher_ready_in} = {8'h00, 1'b1};
		run(op_cipher);
		check("fast cipher", {cyc[2:0], c_start, c_dec}, {3'h1, 2'b10});
		{stat_in, cipher_ready_in} = {8'h20, 1'b0};
		run(op_cipher);
		check("slow cipher", {cyc[2:0], c_start, c_dec}, {3'h2, 2'b11});
		{z_in, seg_in, pc_in, stat_in} = {16'hBEEF, 6'h2A, 22'h3F0000, 8'hFF};
		for (int i = 0; i < 4; i++) begin
			run(mbu_op_t'(int'(op_ptr_goto) + i));
			check("indirect pc", c_pc, {(i % 2 == 1) ? seg_in : 6'h00, z_in});
			check("indirect cycles", cyc, (i < 2) ? 2 : (i == 2) ? int'(CYC_CALL) : 3);
			check("push", {c_push, c_swe}, {i >= 2, 1'b0});
			if (i >= 2) begin
				check("push address", c_paddr, pc_in + PC_STEP);
			end
		end
		{stack_data_in, stat_in} = {22'h2ABCDE, 8'h15};
		run(op_sub_return);
		check("return", {c_pc, c_pop, c_swe}, {stack_data_in, 2'b10});
		check("return cycles", cyc, int'(CYC_RET));
		run(op_int_return);
		check("int return", {c_pc, c_pop, c_swe, c_stat}, {stack_data_in, 2'b11, 8'h95});
		// 5A has bit 3 set and bit 2 clear; odd t[1] selects equal operands and bit 3
		for (int i = 0; i < 5; i++) begin
			for (int t = 0; t < 4; t++) begin
				{next_two_word_in, rd_in, rr_in, io_reg_in} = {t[0], t[1] ? 8'h5A : 8'hA5, 16'h5A5A};
				{bit_sel_in, pc_in} = {t[1] ? 3'h3 : 3'h2, 22'h000200};
				sk = (i == 1 || i == 3) ? !t[1] : t[1];
				adv = sk ? (t[0] ? SKIP_TWO : SKIP_ONE) : PC_STEP;
				run(mbu_op_t'(int'(op_cmp_skip) + i));
				check("skip pc", {c_pc, c_skip}, {pc_in + adv, sk});
				check("skip cycles", cyc, int'(adv) + (i >= 3));
			end
		end
		for (int i = 0; i < 13; i++) begin
			for (int j = 0; j < 4; j++) begin
				op = mbu_op_t'(int'(op_br_set) + i);
				{stat_in, flag_sel_in, pc_in} = {sv[j], 3'(i + j), 22'h000400};
				k_in = j[0] ? 12'h800 : 12'h7FF;
				tk = take(op, sv[j], 3'(i + j));
				run(op);
				check("branch cycles", cyc, tk ? 2 : 1);
				check("branch pc", c_pc, tk ? pc_in + {{10{k_in[11]}}, k_in} + PC_STEP
					: pc_in + PC_STEP);
				check("branch flags kept", c_swe, 1'b0);
			end
		end
		wrap_up();
	end

	// the whole sequence needs well under ten microseconds
	initial begin
		#50000;
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire
